// ==== inc/tscr_pkg.sv ====
// Package for the tile status and control register bank.
// Assumes a processor status port with 8-bit register numbers.
`default_nettype none
package tscr_pkg;
	// ==========================================================
	// Register numbers
	localparam logic [7:0] REG_TILE_CTRL   = 8'h02;
	localparam logic [7:0] REG_BOOT_STAT   = 8'h03;
	localparam logic [7:0] REG_SECURITY    = 8'h05;
	localparam logic [7:0] REG_RO_CTRL     = 8'h06;
	localparam logic [7:0] REG_RO_TILE_CEL = 8'h07;
	localparam logic [7:0] REG_RO_TILE_WIR = 8'h08;
	localparam logic [7:0] REG_RO_PER_CEL  = 8'h09;
	localparam logic [7:0] REG_RO_PER_WIR  = 8'h0a;
	// ==========================================================
	// Tile control fields
	localparam int TC_DLY_LSB = 18;
	localparam int TC_DLY_W   = 8;
	localparam int TC_DIV_LSB = 9;
	localparam int TC_DIV_W   = 9;
	localparam int TC_RGMII   = 8;
	localparam int TC_DYN     = 5;
	localparam int TC_CDIV_EN = 4;
	localparam int TC_UTMI    = 2;
	localparam int TC_ULPI_EN = 1;
	localparam logic [31:0] TC_MASK  = 32'h03ff_ff36;
	localparam logic [31:0] TC_RESET = 32'h0000_0000;
	// ==========================================================
	// Boot status fields
	localparam int BS_PROC_LSB = 16;
	localparam int BS_OVR      = 8;
	localparam int BS_CORE1OFF = 5;
	localparam int BS_NO_POLL  = 4;
	localparam int BS_RAM      = 3;
	localparam int BS_JTAG     = 2;
	localparam logic [31:0] BS_RESET = 32'h0000_0000;
	// ==========================================================
	// Security configuration fields
	localparam int SC_LOCK      = 31;
	localparam int SC_NO_GDBG   = 14;
	localparam int SC_LOCK_ALL  = 12;
	localparam int SC_SECT_LSB  = 8;
	localparam int SC_REDUND    = 7;
	localparam int SC_OTP_BOOT  = 5;
	localparam int SC_NO_JCFG   = 4;
	localparam int SC_NO_TAP    = 0;
	localparam logic [31:0] SC_MASK  = 32'h8000_5fb1;
	localparam logic [31:0] SC_RESET = 32'h0000_0000;
	// ==========================================================
	// Ring oscillator control and counters
	localparam int RO_CORE_EN = 1;
	localparam int RO_PER_EN  = 0;
	localparam logic [1:0] RO_RESET = 2'h0;
	localparam int RO_CNT_W   = 16;
	localparam int RO_NUM     = 4;
endpackage
`default_nettype wire

// ==== hw/tscr_regs.sv ====
// Tile status and control register bank behind the processor status port.
// Assumes clock_i is the PLL output clock and oscillator edges arrive
// already synchronous to it.
//
// Operation
// R1: Eight-bit transmit data delay, resets zero
// R2: Transmit clock high at divider, low at half
// R3: Software loads divider as ratio minus one
// R4: Ethernet ports connected only while enabled
// R5: Dynamic mode divides only when threads paused
// R6: Divider enable divides clock for low power
// R7: Select bit one UTMI, zero ULPI
// R8: ULPI support module active while enabled
// R9: Read-only boot status with processor number
// R10: Boot pins and flags in documented bits
// R11: Top security bit refuses further writes
// R12: Sector locks, lock-all and debug disable
// R13: JTAG config, TAP, OTP boot, redundancy
// R14: Security register loaded from OTP copy
// R15: Four oscillators with counters, software started
// R16: Read counter ten cycles after stopping
// R17: Bit one core, bit zero peripheral
// R18: Sixteen-bit counts in four consecutive registers
// R19: Counters keep values through system reset
// R20: Oscillators run asynchronously, random source
// R21: Software forms identifier from register number
// R22: Reserved bits read zero, ignore writes
// R23: Counters advance per cycle, wrap to zero
`default_nettype none
module tscr_regs (
	input  wire logic        clock_i,
	input  wire logic        rst_n_i,
	// Processor status port
	input  wire logic        ps_wr_i,
	input  wire logic        ps_rd_i,
	input  wire logic [7:0]  ps_addr_i,
	input  wire logic [31:0] ps_wdata_i,
	output logic      [31:0] ps_rdata_o,
	output logic             ps_rvalid_o,
	// Boot straps and tile state
	input  wire logic [7:0]  proc_num_i,
	input  wire logic [1:0]  boot_pll_mode_i,
	input  wire logic        boot_jtag_i,
	input  wire logic        boot_ram_i,
	input  wire logic        skip_otp_poll_i,
	input  wire logic        core1_off_i,
	input  wire logic        boot_mode_ovr_i,
	input  wire logic        threads_paused_i,
	// Security copy from OTP
	input  wire logic        otp_sec_load_i,
	input  wire logic [31:0] otp_sec_data_i,
	// Ring oscillator edges: tile cell, tile wire, periph cell, wire
	input  wire logic [3:0]  ro_osc_i,
	// Control outputs
	output logic [7:0]       rgmii_tx_delay_o,
	output logic             rgmii_tx_clk_o,
	output logic             rgmii_ports_en_o,
	output logic             clk_div_active_o,
	output logic             usb_utmi_mode_o,
	output logic             ulpi_support_en_o,
	output logic [3:0]       ro_run_o,
	output logic [3:0]       otp_sector_lock_o,
	output logic             otp_lock_all_o,
	output logic             otp_redundancy_o,
	output logic             otp_boot_force_o,
	output logic             jtag_cfg_block_o,
	output logic             jtag_tap_block_o,
	output logic             global_debug_block_o,
	output logic             security_locked_o
);
	// ==========================================================
	// Read decode
	logic [31:0] tc_q, tc_d;
	logic [31:0] bs_q, bs_d;
	logic [31:0] sc_q, sc_d;
	logic [1:0]  roc_q, roc_d;
	logic [15:0] ro_cnt_q [4];
	logic [15:0] ro_cnt_d [4];
	logic [3:0]  ro_prev_q, ro_prev_d;
	logic [31:0] rdata_q, rdata_d;
	logic        rvalid_q, rvalid_d;

	function automatic logic [31:0] cnt_word(input logic [15:0] c);
		cnt_word = {16'h0000, c}; // see R22
	endfunction

	function automatic logic [31:0] read_mux(input logic [7:0] a);
		case (a)
			tscr_pkg::REG_TILE_CTRL:   read_mux = tc_q;
			tscr_pkg::REG_BOOT_STAT:   read_mux = bs_q;
			tscr_pkg::REG_SECURITY:    read_mux = sc_q;
			tscr_pkg::REG_RO_CTRL:     read_mux = {30'h0, roc_q};
			tscr_pkg::REG_RO_TILE_CEL: read_mux = cnt_word(ro_cnt_q[0]); // see R18
			tscr_pkg::REG_RO_TILE_WIR: read_mux = cnt_word(ro_cnt_q[1]);
			tscr_pkg::REG_RO_PER_CEL:  read_mux = cnt_word(ro_cnt_q[2]);
			tscr_pkg::REG_RO_PER_WIR:  read_mux = cnt_word(ro_cnt_q[3]);
			default:                   read_mux = 32'h0000_0000;
		endcase
	endfunction

	// ==========================================================
	// Write decode
	// One enable per writable register keeps the next-state logic flat
	logic tc_we;
	logic sc_we;
	logic roc_we;
	logic sec_open;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		hit = (a == r);
	endfunction

	assign tc_we    = ps_wr_i && hit(ps_addr_i, tscr_pkg::REG_TILE_CTRL);
	assign sc_we    = ps_wr_i && hit(ps_addr_i, tscr_pkg::REG_SECURITY);
	assign roc_we   = ps_wr_i && hit(ps_addr_i, tscr_pkg::REG_RO_CTRL);
	// Lock only guards software; the OTP copy still reaches the register
	assign sec_open = !sc_q[tscr_pkg::SC_LOCK]; // see R11

	// ==========================================================
	// Register group: control, status, security
	always_comb begin
		tc_d     = tc_q;
		sc_d     = sc_q;
		roc_d    = roc_q;
		rdata_d  = rdata_q;
		rvalid_d = ps_rd_i;
		bs_d     = 32'h0000_0000;
		// Straps are sampled every cycle; the register never takes writes
		bs_d[tscr_pkg::BS_PROC_LSB +: 8] = proc_num_i;   // see R9
		bs_d[1:0]                     = boot_pll_mode_i; // see R10
		bs_d[tscr_pkg::BS_JTAG]       = boot_jtag_i;
		bs_d[tscr_pkg::BS_RAM]        = boot_ram_i;
		bs_d[tscr_pkg::BS_NO_POLL]    = skip_otp_poll_i;
		bs_d[tscr_pkg::BS_CORE1OFF]   = core1_off_i;
		bs_d[tscr_pkg::BS_OVR]        = boot_mode_ovr_i;
		// Writes to read-only or unmapped numbers match no enable
		if (tc_we) begin
			tc_d = ps_wdata_i & tscr_pkg::TC_MASK; // see R22
		end
		if (sc_we && sec_open) begin
			sc_d = ps_wdata_i & tscr_pkg::SC_MASK; // see R12, R13
		end
		if (roc_we) begin
			roc_d = ps_wdata_i[1:0]; // see R17
		end
		// OTP copy wins over a software write in the same cycle
		if (otp_sec_load_i) begin
			sc_d = otp_sec_data_i & tscr_pkg::SC_MASK; // see R14
		end
		if (ps_rd_i) begin
			rdata_d = read_mux(ps_addr_i);
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tc_q     <= tscr_pkg::TC_RESET; // see R1
			bs_q     <= tscr_pkg::BS_RESET;
			sc_q     <= tscr_pkg::SC_RESET;
			roc_q    <= tscr_pkg::RO_RESET;
			rdata_q  <= 32'h0000_0000;
			rvalid_q <= 1'b0;
		end else begin
			tc_q     <= tc_d;
			bs_q     <= bs_d;
			sc_q     <= sc_d;
			roc_q    <= roc_d;
			rdata_q  <= rdata_d;
			rvalid_q <= rvalid_d;
		end
	end

	// ==========================================================
	// Ethernet transmit clock divider
	logic [8:0] div_val;
	logic [8:0] txc_cnt_q, txc_cnt_d;
	logic       txc_q, txc_d;
	logic       rgmii_en;

	assign div_val  = tc_q[tscr_pkg::TC_DIV_LSB +: tscr_pkg::TC_DIV_W];
	assign rgmii_en = tc_q[tscr_pkg::TC_RGMII];

	// Divider holds ratio minus one, so the period is div_val + 1
	always_comb begin
		txc_cnt_d = (txc_cnt_q >= div_val) ? 9'h000 : txc_cnt_q + 9'h001; // see R3
		txc_d     = txc_q;
		if (!rgmii_en) begin
			txc_cnt_d = 9'h000;
			txc_d     = 1'b0;
		end else if (txc_cnt_q == div_val) begin
			txc_d = 1'b1; // see R2
		end else if (txc_cnt_q == (div_val >> 1)) begin
			txc_d = 1'b0; // see R2
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			txc_cnt_q <= 9'h000;
			txc_q     <= 1'b0;
		end else begin
			txc_cnt_q <= txc_cnt_d;
			txc_q     <= txc_d;
		end
	end

	// ==========================================================
	// Ring oscillator counters
	// No reset here, so a count survives a system reset; its power-up
	// value is undefined, which suits its use as an entropy source
	logic [3:0] ro_run;

	assign ro_run = {roc_q[tscr_pkg::RO_PER_EN], roc_q[tscr_pkg::RO_PER_EN],
	                 roc_q[tscr_pkg::RO_CORE_EN], roc_q[tscr_pkg::RO_CORE_EN]};

	always_comb begin
		ro_prev_d = ro_osc_i;
		for (int i = 0; i < tscr_pkg::RO_NUM; i++) begin
			ro_cnt_d[i] = ro_cnt_q[i];
			// One count per oscillator rising edge, wrapping naturally
			if (ro_run[i] && ro_osc_i[i] && !ro_prev_q[i]) begin
				ro_cnt_d[i] = ro_cnt_q[i] + 16'h0001; // see R23, R15
			end
		end
	end

	always_ff @(posedge clock_i) begin
		ro_prev_q <= ro_prev_d;
		for (int i = 0; i < tscr_pkg::RO_NUM; i++) begin
			ro_cnt_q[i] <= ro_cnt_d[i]; // see R19, R20
		end
	end

	// ==========================================================
	// Outputs
	assign ps_rdata_o        = rdata_q;
	assign ps_rvalid_o       = rvalid_q;
	assign rgmii_tx_delay_o  = tc_q[tscr_pkg::TC_DLY_LSB +: tscr_pkg::TC_DLY_W];
	assign rgmii_tx_clk_o    = txc_q;
	assign rgmii_ports_en_o  = rgmii_en; // see R4
	assign clk_div_active_o  = tc_q[tscr_pkg::TC_CDIV_EN] &
		(~tc_q[tscr_pkg::TC_DYN] | threads_paused_i); // see R5, R6
	assign usb_utmi_mode_o   = tc_q[tscr_pkg::TC_UTMI];    // see R7
	assign ulpi_support_en_o = tc_q[tscr_pkg::TC_ULPI_EN]; // see R8
	assign ro_run_o          = ro_run; // see R15
	assign otp_sector_lock_o = sc_q[tscr_pkg::SC_SECT_LSB +: 4];
	assign otp_lock_all_o    = sc_q[tscr_pkg::SC_LOCK_ALL];
	assign otp_redundancy_o  = sc_q[tscr_pkg::SC_REDUND];
	assign otp_boot_force_o  = sc_q[tscr_pkg::SC_OTP_BOOT];
	assign jtag_cfg_block_o  = sc_q[tscr_pkg::SC_NO_JCFG];
	assign jtag_tap_block_o  = sc_q[tscr_pkg::SC_NO_TAP];
	assign global_debug_block_o = sc_q[tscr_pkg::SC_NO_GDBG];
	assign security_locked_o = sc_q[tscr_pkg::SC_LOCK];
endmodule
`default_nettype wire

// ==== verif/tscr_regs_monitor.sv ====
// Checker for the tile status and control register bank.
// Assumes it is bound to tscr_regs and sees only its ports.
`default_nettype none
module tscr_regs_monitor (
	input wire logic        clock_i,
	input wire logic        rst_n_i,
	input wire logic        ps_wr_i,
	input wire logic        ps_rd_i,
	input wire logic [7:0]  ps_addr_i,
	input wire logic [31:0] ps_wdata_i,
	input wire logic [31:0] ps_rdata_o,
	input wire logic        ps_rvalid_o,
	input wire logic        otp_sec_load_i,
	input wire logic        security_locked_o,
	input wire logic [7:0]  rgmii_tx_delay_o,
	input wire logic        rgmii_ports_en_o,
	input wire logic        rgmii_tx_clk_o,
	input wire logic        usb_utmi_mode_o,
	input wire logic [3:0]  ro_run_o
);
	// ==========================================
	// Assertions
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	logic tc_wr, ro_wr;
	assign tc_wr = ps_wr_i && ps_addr_i == 8'h02;
	assign ro_wr = ps_wr_i && ps_addr_i == 8'h06;
	chk_read_answer: assert property (ps_rd_i |=> ps_rvalid_o)
		else $error("read not answered next cycle");
	chk_answer_cause: assert property (ps_rvalid_o |-> $past(ps_rd_i))
		else $error("read answer without request");
	chk_lock_holds: assert property
		(security_locked_o && !otp_sec_load_i |=> security_locked_o)
		else $error("security lock cleared by write");
	chk_delay_write: assert property
		(tc_wr |=> rgmii_tx_delay_o == $past(ps_wdata_i[25:18]))
		else $error("tx delay not updated");
	chk_ports_write: assert property
		(tc_wr |=> rgmii_ports_en_o == $past(ps_wdata_i[8]))
		else $error("port enable not updated");
	chk_utmi_write: assert property
		(tc_wr |=> usb_utmi_mode_o == $past(ps_wdata_i[2]))
		else $error("usb mode not updated");
	chk_txclk_idle: assert property
		(!rgmii_ports_en_o [*2] |-> !rgmii_tx_clk_o)
		else $error("tx clock runs while disabled");
	chk_ro_run: assert property (ro_wr |=> ro_run_o ==
		{{2{$past(ps_wdata_i[0])}}, {2{$past(ps_wdata_i[1])}}})
		else $error("oscillator enables wrong");
	chk_count_upper: assert property (ps_rvalid_o &&
		$past(ps_addr_i) inside {[8'h07:8'h0a]} |-> ps_rdata_o[31:16] == 0)
		else $error("counter reserved bits set");
	cov_locked: cover property ($rose(security_locked_o));
	cov_txclk: cover property ($rose(rgmii_tx_clk_o));
	cov_read: cover property (ps_rvalid_o);
endmodule
bind tscr_regs tscr_regs_monitor i_tscr_regs_monitor (.clock_i, .rst_n_i,
	.ps_wr_i, .ps_rd_i, .ps_addr_i, .ps_wdata_i, .ps_rdata_o, .ps_rvalid_o,
	.otp_sec_load_i, .security_locked_o, .rgmii_tx_delay_o,
	.rgmii_ports_en_o, .rgmii_tx_clk_o, .usb_utmi_mode_o, .ro_run_o);
`default_nettype wire

// ==== verif/tb_top.sv ====
// Self-checking bench for the tile status and control register bank.
// Assumes the bank answers reads one cycle after the strobe.
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_i = 0, rst_n_i = 0, ps_wr_i = 0, ps_rd_i = 0;
	logic boot_jtag_i = 1, boot_ram_i = 0, skip_otp_poll_i = 1;
	logic core1_off_i = 0, boot_mode_ovr_i = 1, threads_paused_i = 0;
	logic otp_sec_load_i = 0, ps_rvalid_o, rgmii_tx_clk_o, otp_redundancy_o;
	logic rgmii_ports_en_o, clk_div_active_o, usb_utmi_mode_o, otp_lock_all_o;
	logic ulpi_support_en_o, otp_boot_force_o, jtag_cfg_block_o;
	logic jtag_tap_block_o, global_debug_block_o, security_locked_o;
	logic [7:0]  ps_addr_i = 8'h00, proc_num_i = 8'ha5, rgmii_tx_delay_o;
	logic [1:0]  boot_pll_mode_i = 2'h2;
	logic [3:0]  ro_osc_i = 4'h0, ro_run_o, otp_sector_lock_o;
	logic [31:0] ps_wdata_i = 32'h0, otp_sec_data_i = 32'h0, ps_rdata_o, q;
	int num_errors = 0, tests_run = 0, cyc = 0, hi;
	tscr_regs i_tscr_regs (.clock_i, .rst_n_i, .ps_wr_i, .ps_rd_i,
		.ps_addr_i, .ps_wdata_i, .ps_rdata_o, .ps_rvalid_o, .proc_num_i,
		.boot_pll_mode_i, .boot_jtag_i, .boot_ram_i, .skip_otp_poll_i,
		.core1_off_i, .boot_mode_ovr_i, .threads_paused_i, .otp_sec_load_i,
		.otp_sec_data_i, .ro_osc_i, .rgmii_tx_delay_o, .rgmii_tx_clk_o,
		.rgmii_ports_en_o, .clk_div_active_o, .usb_utmi_mode_o,
		.ulpi_support_en_o, .ro_run_o, .otp_sector_lock_o, .otp_lock_all_o,
		.otp_redundancy_o, .otp_boot_force_o, .jtag_cfg_block_o,
		.jtag_tap_block_o, .global_debug_block_o, .security_locked_o);
	always #10 clock_i = ~clock_i;
	// Oscillator edges at different rates so each counter sees traffic
	always @(negedge clock_i) ro_osc_i <= ro_osc_i + 4'h1;
	// Whole run needs well under a thousand cycles
	always @(posedge clock_i) begin
		cyc++;
		if (cyc == 3000) begin
			num_errors++;
			finish_test();
		end
	end
	// ==========================================
	// Bus and compare tasks
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
			num_errors++;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(negedge clock_i) {ps_wr_i, ps_addr_i, ps_wdata_i} = {1'b1, a, d};
		@(negedge clock_i) ps_wr_i = 0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(negedge clock_i) {ps_rd_i, ps_addr_i} = {1'b1, a};
		@(negedge clock_i) ps_rd_i = 0;
		q = ps_rdata_o;
	endtask
	// ==========================================
	// Scenarios
	task automatic t_reset;
		rd(8'h02); chk(q, 32'h0);
		rd(8'h06); chk(q, 32'h0);
		rd(8'h04); chk(q, 32'h0);
		rd(8'h03); chk(q, 32'h00a5_0116);
		$display("reset values done");
	endtask
	task automatic t_tile;
		wr(8'h02, 32'hffff_ffff);
		rd(8'h02); chk(q, tscr_pkg::TC_MASK);
		chk(rgmii_tx_delay_o, 32'hff);
		chk({usb_utmi_mode_o, ulpi_support_en_o}, 32'h3);
		chk(clk_div_active_o, 32'h0);
		wr(8'h02, 32'h0);
		chk(rgmii_ports_en_o, 32'h0);
		wr(8'h02, 32'h0000_0900);
		repeat (10) @(negedge clock_i);
		hi = 0;
		repeat (40) @(negedge clock_i) hi += int'(rgmii_tx_clk_o === 1'b1);
		chk(hi, 32'd24);
		wr(8'h02, 32'h10);
		chk(clk_div_active_o, 32'h1);
		wr(8'h02, 32'h30);
		threads_paused_i = 1;
		#1 chk(clk_div_active_o, 32'h1);
		$display("tile control done");
	endtask
	task automatic t_secure;
		wr(8'h05, 32'hffff_4001);
		rd(8'h05); chk(q, 32'h8000_4001);
		chk({jtag_tap_block_o, global_debug_block_o}, 32'h3);
		@(negedge clock_i) {otp_sec_load_i, otp_sec_data_i} = {1'b1, 32'h0};
		@(negedge clock_i) otp_sec_load_i = 0;
		wr(8'h05, 32'hffff_ffff);
		rd(8'h05); chk(q, tscr_pkg::SC_MASK);
		wr(8'h05, 32'h0);
		rd(8'h05); chk(q, tscr_pkg::SC_MASK);
		chk({otp_sector_lock_o, otp_lock_all_o, otp_redundancy_o,
			otp_boot_force_o, jtag_cfg_block_o}, 32'hff);
		$display("security done");
	endtask
	task automatic t_ring;
		wr(8'h06, 32'hffff_ffff);
		rd(8'h06); chk(q, 32'h3);
		wr(8'h06, 32'h1); chk(ro_run_o, 32'hc);
		wr(8'h06, 32'h0);
		repeat (10) @(negedge clock_i);
		for (int a = 7; a <= 10; a++) begin
			rd(a[7:0]); chk(q[31:16], 32'h0);
		end
		$display("ring oscillators done");
	endtask
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clock_i);
		@(negedge clock_i) rst_n_i = 1;
		t_reset();
		t_tile();
		t_secure();
		t_ring();
		finish_test();
	end
endmodule
`default_nettype wire
